/* include/flash_pin_pkg.sv */
package flash_pin_pkg;
   // lane usage chosen by the instruction decoder for the current phase
   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_DUAL = 2'b01,
      MODE_QUAD = 2'b10
   } lane_mode_e;

   // link state as seen from the select pin
   typedef enum logic [1:0] {
      LINK_UNARMED = 2'b00,
      LINK_STANDBY = 2'b01,
      LINK_SELECTED = 2'b10
   } link_state_e;

   // one received byte; first marks the instruction byte of a selection
   typedef struct packed {
      logic first;
      logic [7:0] data;
   } rx_word_s;

   localparam int RX_WORD_W = 9;
   localparam int RX_DEPTH = 2;
   localparam logic [1:0] SYNC_RESET = 2'h0;
   localparam logic CS_PREV_RESET = 1'b0;
   localparam logic [2:0] BIT_CNT_RESET = 3'h0;
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   localparam logic [7:0] IDLE_OUT_BYTE = 8'hFF;
   localparam logic [3:0] LANES_RESET = 4'h0;
endpackage

/* design/rx_buffer.sv */
`timescale 1ns/10ps
module rx_buffer #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   input wire logic core_clk, // system clock
   input wire logic reset, // synchronous, active high
   input wire logic in_valid, // word offered
   output logic in_ready, // space free
   input wire logic [WIDTH-1:0] in_data, // word in
   output logic out_valid, // word held
   input wire logic out_ready, // receiver takes word
   output logic [WIDTH-1:0] out_data // oldest word
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [CW-1:0] count_q;
   logic push;
   logic pop;

   assign in_ready = (count_q != FULL);
   assign out_valid = (count_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule // rx_buffer

/* design/flash_pin_front.sv */
// What this block does
// (RULE_01) select high: all lanes undriven
// (RULE_02) select low: selected, leaves standby, accepts traffic
// (RULE_03) nothing accepted before first select falling edge
// (RULE_04) lane data ignored while select high
// (RULE_05) deselected: standby low-power indication
// (RULE_06) single lane: sample lane0 on clock rise
// (RULE_07) single lane: drive lane1 on clock fall
// (RULE_08) dual/quad: lanes in on rise, out on fall
// (RULE_09) quad: protect and pause pins become lanes 2, 3
// (RULE_10) lane3 function bit picks pause or reset
// (RULE_11) bit clear pause, bit set hardware reset
// (RULE_12) quad enable disables write protect on lane2
// (RULE_13) pause: float output, keep shift state
// (RULE_14) host uses clock mode 0 or 3
// (RULE_15) select high abandons partial byte
// (RULE_16) lanes driven only in selected output phase
`timescale 1ns/10ps
module flash_pin_front #(
   parameter int DEPTH = flash_pin_pkg::RX_DEPTH
) (
   input wire logic core_clk, // 200 MHz system clock
   input wire logic reset, // synchronous, active high
   input wire logic select_n, // select pin, active low
   input wire logic sclk, // serial clock pin from host
   input wire logic [3:0] lane_in, // lane pin levels
   output logic [3:0] lane_out, // lane output levels
   output logic [3:0] lane_oe, // lane output enables
   input wire flash_pin_pkg::lane_mode_e lane_mode, // lane usage of phase
   input wire logic out_phase, // decoder is in output phase
   input wire logic quad_lane_enable_bit, // quad enable status bit
   input wire logic lane3_function_bit, // 0 pause, 1 hardware reset
   input wire logic [7:0] tx_data, // next byte to send
   input wire logic tx_valid, // tx_data available
   output logic tx_ready, // tx_data taken this cycle
   output flash_pin_pkg::rx_word_s rx_word, // received byte
   output logic rx_valid, // rx_word held
   input wire logic rx_ready, // receiver takes rx_word
   output logic rx_overrun, // byte lost, one-cycle pulse
   output logic selected, // link selected
   output logic low_power_standby, // standby indication
   output logic pause_active, // paused while selected
   output logic hw_reset_req, // hardware reset from lane3
   output logic write_protect_active // protect pin asserted
);
   logic [1:0] cs_sync_q;
   logic [1:0] clk_sync_q;
   logic [3:0] lane_sync1_q;
   logic [3:0] lane_s_q;
   logic cs_prev_q;
   logic clk_prev_q;
   logic cs_s;
   logic clk_s;
   logic cs_fall;
   logic clk_rise;
   logic clk_fall;
   flash_pin_pkg::link_state_e link_q;
   logic shift_ok;
   logic in_take;
   logic out_take;
   logic [2:0] in_cnt_q;
   logic [2:0] out_cnt_q;
   logic [7:0] in_sr_q;
   logic [7:0] out_sr_q;
   logic [7:0] out_next;
   logic [7:0] in_next;
   logic [3:0] in_sum;
   logic byte_done;
   logic first_q;
   logic [3:0] lane_out_q;
   flash_pin_pkg::rx_word_s hold_q;
   logic hold_valid_q;
   logic buf_ready;

   function automatic logic [3:0] lane_width(input flash_pin_pkg::lane_mode_e m);
      case (m)
         flash_pin_pkg::MODE_DUAL: lane_width = 4'h2;
         flash_pin_pkg::MODE_QUAD: lane_width = 4'h4;
         default: lane_width = 4'h1;
      endcase
   endfunction

   // second synchroniser stage feeds everything, first stage only the second
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cs_sync_q <= flash_pin_pkg::SYNC_RESET;
         clk_sync_q <= flash_pin_pkg::SYNC_RESET;
         lane_sync1_q <= flash_pin_pkg::LANES_RESET;
         lane_s_q <= flash_pin_pkg::LANES_RESET;
         cs_prev_q <= flash_pin_pkg::CS_PREV_RESET;
         clk_prev_q <= 1'b0;
      end else begin
         cs_sync_q <= {cs_sync_q[0], select_n};
         clk_sync_q <= {clk_sync_q[0], sclk};
         lane_sync1_q <= lane_in;
         lane_s_q <= lane_sync1_q;
         cs_prev_q <= cs_sync_q[1];
         clk_prev_q <= clk_sync_q[1];
      end
   end

   assign cs_s = cs_sync_q[1];
   assign clk_s = clk_sync_q[1];
   // (RULE_03) falling edge detect; prev resets low so a low pin at start is no edge
   assign cs_fall = cs_prev_q & ~cs_s;
   // (RULE_14) edges of either idle level
   assign clk_rise = clk_s & ~clk_prev_q;
   assign clk_fall = ~clk_s & clk_prev_q;

   // (RULE_09) lane3 is the pause or reset pin unless quad enable
   // (RULE_10) (RULE_11) function bit picks pause or reset
   assign hw_reset_req = ~quad_lane_enable_bit & lane3_function_bit & ~lane_s_q[3];
   assign pause_active = ~quad_lane_enable_bit & ~lane3_function_bit & ~lane_s_q[3] & selected;
   // (RULE_12) protect function only without quad enable
   assign write_protect_active = ~quad_lane_enable_bit & ~lane_s_q[2];

   // (RULE_02) link state from select pin
   always_ff @(posedge core_clk) begin
      if (reset) begin
         link_q <= flash_pin_pkg::LINK_UNARMED;
      end else begin
         case (link_q)
            flash_pin_pkg::LINK_UNARMED: begin
               if (cs_fall && !hw_reset_req) begin
                  link_q <= flash_pin_pkg::LINK_SELECTED;
               end
            end
            flash_pin_pkg::LINK_STANDBY: begin
               if (cs_fall && !hw_reset_req) begin
                  link_q <= flash_pin_pkg::LINK_SELECTED;
               end
            end
            flash_pin_pkg::LINK_SELECTED: begin
               if (cs_s || hw_reset_req) begin
                  link_q <= flash_pin_pkg::LINK_STANDBY;
               end
            end
            default: link_q <= flash_pin_pkg::LINK_UNARMED;
         endcase
      end
   end

   assign selected = (link_q == flash_pin_pkg::LINK_SELECTED);
   // (RULE_05) standby whenever not selected
   assign low_power_standby = ~selected;

   // (RULE_04) shifting only while selected and select still low
   assign shift_ok = selected & ~cs_s & ~pause_active & ~hw_reset_req;
   // (RULE_06) inbound bits on clock rise
   assign in_take = shift_ok & clk_rise &
                    ((lane_mode == flash_pin_pkg::MODE_SINGLE) | ~out_phase);
   // (RULE_07) outbound bits on clock fall
   assign out_take = shift_ok & clk_fall & out_phase;

   always_comb begin
      case (lane_mode)
         flash_pin_pkg::MODE_DUAL: in_next = {in_sr_q[5:0], lane_s_q[1:0]};
         flash_pin_pkg::MODE_QUAD: in_next = {in_sr_q[3:0], lane_s_q[3:0]};
         default: in_next = {in_sr_q[6:0], lane_s_q[0]};
      endcase
   end

   assign in_sum = {1'b0, in_cnt_q} + lane_width(lane_mode);
   assign byte_done = in_take & in_sum[3];

   // (RULE_15) counters restart whenever the link is not selected or select is high
   always_ff @(posedge core_clk) begin
      if (reset || !selected || cs_s) begin
         in_cnt_q <= flash_pin_pkg::BIT_CNT_RESET;
         in_sr_q <= flash_pin_pkg::SHIFT_RESET;
      end else if (in_take) begin
         in_cnt_q <= in_sum[2:0];
         in_sr_q <= in_next;
      end
   end

   // first byte of each selection is the instruction
   always_ff @(posedge core_clk) begin
      if (reset) begin
         first_q <= 1'b0;
      end else if (cs_fall) begin
         first_q <= 1'b1;
      end else if (byte_done) begin
         first_q <= 1'b0;
      end
   end

   // holding slot ahead of the buffer; a new byte wins over the drain
   always_ff @(posedge core_clk) begin
      if (reset) begin
         hold_valid_q <= 1'b0;
         hold_q <= '0;
         rx_overrun <= 1'b0;
      end else begin
         rx_overrun <= byte_done & hold_valid_q & ~buf_ready;
         if (byte_done) begin
            hold_valid_q <= 1'b1;
            hold_q <= '{first: first_q, data: in_next};
         end else if (buf_ready) begin
            hold_valid_q <= 1'b0;
         end
      end
   end

   rx_buffer #(
      .WIDTH(flash_pin_pkg::RX_WORD_W),
      .DEPTH(DEPTH)
   ) u_rx_buffer (
      .core_clk(core_clk),
      .reset(reset),
      .in_valid(hold_valid_q),
      .in_ready(buf_ready),
      .in_data(hold_q),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_word)
   );

   // new byte taken at the start of each outbound byte; idle bytes read as ones
   assign out_next = (out_cnt_q == flash_pin_pkg::BIT_CNT_RESET) ?
                     (tx_valid ? tx_data : flash_pin_pkg::IDLE_OUT_BYTE) : out_sr_q;
   assign tx_ready = out_take & (out_cnt_q == flash_pin_pkg::BIT_CNT_RESET);

   // (RULE_08) present next bits on each fall of the output phase
   always_ff @(posedge core_clk) begin
      if (reset || !selected || cs_s) begin
         out_cnt_q <= flash_pin_pkg::BIT_CNT_RESET;
         out_sr_q <= flash_pin_pkg::SHIFT_RESET;
         lane_out_q <= flash_pin_pkg::LANES_RESET;
      end else if (out_take) begin
         out_cnt_q <= 3'(out_cnt_q + lane_width(lane_mode));
         case (lane_mode)
            flash_pin_pkg::MODE_DUAL: begin
               lane_out_q <= {2'b00, out_next[7:6]};
               out_sr_q <= {out_next[5:0], 2'b00};
            end
            flash_pin_pkg::MODE_QUAD: begin
               lane_out_q <= out_next[7:4];
               out_sr_q <= {out_next[3:0], 4'h0};
            end
            default: begin
               lane_out_q <= {2'b00, out_next[7], 1'b0};
               out_sr_q <= {out_next[6:0], 1'b0};
            end
         endcase
      end
   end

   assign lane_out = lane_out_q;

   // (RULE_16) drive only in selected output phase
   // (RULE_01) enables fall straight from the synchronised select
   // (RULE_13) pause floats the outputs
   always_comb begin
      lane_oe = 4'h0;
      if (selected && !cs_s && out_phase && !pause_active && !hw_reset_req) begin
         case (lane_mode)
            flash_pin_pkg::MODE_DUAL: lane_oe = 4'h3;
            flash_pin_pkg::MODE_QUAD: lane_oe = 4'hF;
            default: lane_oe = 4'h2;
         endcase
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   property p_deselect_float;
      cs_s |-> lane_oe == 4'h0;
   endproperty
   a_deselect_float: assert property (p_deselect_float) // RULE_01
      else $error("lanes driven while deselected");

   property p_select_enters;
      cs_fall && !hw_reset_req |=> selected && !low_power_standby;
   endproperty
   a_select_enters: assert property (p_select_enters) // RULE_02
      else $error("select fall did not select");

   property p_unarmed_quiet;
      link_q == flash_pin_pkg::LINK_UNARMED |=> !hold_valid_q;
   endproperty
   a_unarmed_quiet: assert property (p_unarmed_quiet) // RULE_03
      else $error("byte accepted before first select");

   property p_abandon;
      cs_s |=> in_cnt_q == 3'h0 && out_cnt_q == 3'h0;
   endproperty
   a_abandon: assert property (p_abandon) // RULE_15
      else $error("partial byte kept over deselect");

   property p_single_sample;
      in_take && lane_mode == flash_pin_pkg::MODE_SINGLE |=> in_sr_q[0] == $past(lane_s_q[0]);
   endproperty
   a_single_sample: assert property (p_single_sample) // RULE_06
      else $error("lane0 not sampled on rise");

   property p_out_on_fall;
      selected && !cs_s && $changed(lane_out_q) |-> $past(clk_fall);
   endproperty
   a_out_on_fall: assert property (p_out_on_fall) // RULE_07
      else $error("output changed off a falling edge");

   property p_pause_float;
      pause_active |-> lane_oe == 4'h0;
   endproperty
   a_pause_float: assert property (p_pause_float) // RULE_13
      else $error("output driven during pause");

   property p_pause_hold;
      pause_active && !cs_s && selected |=> $stable(in_cnt_q) && $stable(out_cnt_q);
   endproperty
   a_pause_hold: assert property (p_pause_hold) // RULE_13
      else $error("shift state moved during pause");

   property p_quad_no_protect;
      quad_lane_enable_bit |-> !write_protect_active && !hw_reset_req && !pause_active;
   endproperty
   a_quad_no_protect: assert property (p_quad_no_protect) // RULE_12
      else $error("pin function active under quad enable");

   property p_hw_reset;
      hw_reset_req && selected |=> !selected ##1 !selected;
   endproperty
   a_hw_reset: assert property (p_hw_reset) // RULE_11
      else $error("hardware reset did not deselect");
endmodule // flash_pin_front

/* testbench/spi_host_model.sv */
`timescale 1ns/10ps
module spi_host_model (
   input wire logic [3:0] lanes, // resolved lane levels
   output logic select_n, // select to device, active low
   output logic sclk, // serial clock, also toggled while select is high
   output logic [3:0] drv_v, // host lane levels
   output logic [3:0] drv_oe // host lane enables
);
   logic [3:0] pin_v;
   logic [3:0] pin_oe;
   logic [3:0] bit_v;
   logic [3:0] bit_oe;
   // select and clock low at power-up, so the device must wait for a real falling edge
   initial begin
      pin_v = 4'hF;
      pin_oe = 4'h0;
      bit_v = 4'h0;
      bit_oe = 4'h0;
      select_n = 1'b0;
      sclk = 1'b0;
   end
   assign drv_oe = bit_oe | pin_oe;
   assign drv_v = (bit_oe & bit_v) | (~bit_oe & pin_v);
   task automatic sel(input logic lvl);
      #40 select_n = lvl;
      #40;
   endtask
   task automatic pin(input int idx, input logic oe, input logic v);
      pin_oe[idx] = oe;
      pin_v[idx] = v;
   endtask
   // mode 3 idles high between frames
   task automatic lvl(input logic v);
      #32 sclk = v;
   endtask
   task automatic tick();
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
   endtask
   // host drives before rise, samples on rise
   task automatic xfer(input logic [7:0] tx, input int w, input int n, input logic drv,
                       output logic [7:0] rx);
      logic [3:0] m;
      m = 4'((1 << w) - 1);
      rx = 8'h00;
      for (int i = n - 1; i >= 0; i--) begin
         bit_v = 4'(tx >> (i * w)) & m;
         bit_oe = drv ? m : 4'h0;
         #32 sclk = 1'b1;
         // single lane reads the output line, wider modes read lanes from 0 up
         rx = 8'((rx << w) | ((w == 1) ? {3'b000, lanes[1]} : (lanes & m)));
         #32 sclk = 1'b0;
      end
      bit_oe = 4'h0;
   endtask
endmodule // spi_host_model

/* testbench/tb_flash_pin_front.sv */
`timescale 1ns/10ps
module tb_flash_pin_front;
   localparam logic [7:0] DIN [3] = '{8'hA5, 8'h5A, 8'h3C};
   localparam logic [7:0] DOUT [3] = '{8'h96, 8'h4B, 8'hC3};
   localparam logic [3:0] OE [3] = '{4'h2, 4'h3, 4'hF};
   logic core_clk;
   logic reset;
   logic select_n, sclk, tx_ready, rx_valid, rx_overrun, selected, standby, paused, hw_rst, wp;
   logic [3:0] lane_out, lane_oe, h_v, h_oe;
   wire logic [3:0] lanes;
   flash_pin_pkg::lane_mode_e lane_mode;
   logic out_phase, qe, fn, tx_valid, rx_ready, ovr;
   logic [7:0] tx_data, got;
   flash_pin_pkg::rx_word_s rx_word;
   flash_pin_pkg::rx_word_s rx_q[$];
   int err_total = 0, num_checks = 0, cyc = 0, n_txr = 0;
   // undriven lanes are pulled up
   assign lanes = (lane_oe & lane_out) | (~lane_oe & h_oe & h_v) | (~lane_oe & ~h_oe);
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   flash_pin_front u_flash_pin_front (.core_clk(core_clk), .reset(reset),
      .select_n(select_n), .sclk(sclk), .lane_in(lanes), .lane_out(lane_out),
      .lane_oe(lane_oe), .lane_mode(lane_mode), .out_phase(out_phase),
      .quad_lane_enable_bit(qe), .lane3_function_bit(fn), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_overrun(rx_overrun), .selected(selected),
      .low_power_standby(standby), .pause_active(paused), .hw_reset_req(hw_rst),
      .write_protect_active(wp));
   spi_host_model u_spi_host_model (.lanes(lanes), .select_n(select_n), .sclk(sclk),
      .drv_v(h_v), .drv_oe(h_oe));
   task automatic test_done();
      if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge core_clk) begin
      if (rx_valid === 1'b1 && rx_ready) rx_q.push_back(rx_word);
      if (rx_overrun === 1'b1) ovr = 1'b1;
      if (tx_ready === 1'b1) n_txr++;
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         test_done();
      end
   end
   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic t_unarmed();
      u_spi_host_model.xfer(8'hC3, 1, 8, 1'b1, got);
      idle(8);
      chk("rx_count", 9'h000, 9'(rx_q.size()));
      chk("selected", 9'h000, {8'h00, selected});
      u_spi_host_model.sel(1'b1);
      out_phase = 1'b1;
      u_spi_host_model.xfer(8'h99, 1, 8, 1'b1, got);
      idle(8);
      chk("rx_count", 9'h000, 9'(rx_q.size()));
      chk("lane_oe", 9'h000, {5'h00, lane_oe});
      chk("standby", 9'h001, {8'h00, standby});
      out_phase = 1'b0;
   endtask
   task automatic t_modes();
      for (int k = 0; k < 3; k++) begin
         lane_mode = flash_pin_pkg::lane_mode_e'(k);
         qe = (k == 2);
         rx_q.delete();
         u_spi_host_model.sel(1'b0);
         chk("selected", 9'h001, {8'h00, selected});
         chk("standby", 9'h000, {8'h00, standby});
         u_spi_host_model.xfer(DIN[k], 1 << k, 8 >> k, 1'b1, got);
         idle(8);
         chk("rx_count", 9'h001, 9'(rx_q.size()));
         chk("rx_word", {1'b1, DIN[k]}, rx_q[0]);
         out_phase = 1'b1;
         tx_data = DOUT[k];
         tx_valid = 1'b1;
         n_txr = 0;
         u_spi_host_model.tick();
         u_spi_host_model.xfer(8'h00, 1 << k, 8 >> k, 1'b0, got);
         chk("tx_byte", {1'b0, DOUT[k]}, {1'b0, got});
         chk("lane_oe", {5'h00, OE[k]}, {5'h00, lane_oe});
         idle(1);
         out_phase = 1'b0;
         tx_valid = 1'b0;
         idle(4);
         chk("lane_oe", 9'h000, {5'h00, lane_oe});
         chk("tx_ready", 9'h001, 9'(n_txr));
         u_spi_host_model.sel(1'b1);
         idle(1);
      end
      lane_mode = flash_pin_pkg::MODE_SINGLE;
      qe = 1'b0;
   endtask
   task automatic t_abandon();
      u_spi_host_model.sel(1'b0);
      u_spi_host_model.xfer(8'h0F, 1, 4, 1'b1, got);
      u_spi_host_model.sel(1'b1);
      u_spi_host_model.sel(1'b0);
      rx_q.delete();
      u_spi_host_model.xfer(8'h3C, 1, 8, 1'b1, got);
      idle(8);
      chk("rx_count", 9'h001, 9'(rx_q.size()));
      chk("rx_word", 9'h13C, rx_q[0]);
      u_spi_host_model.sel(1'b1);
   endtask
   task automatic t_mode3();
      u_spi_host_model.lvl(1'b1);
      u_spi_host_model.sel(1'b0);
      rx_q.delete();
      u_spi_host_model.lvl(1'b0);
      u_spi_host_model.xfer(8'hC5, 1, 8, 1'b1, got);
      idle(8);
      chk("rx_count", 9'h001, 9'(rx_q.size()));
      chk("rx_word", 9'h1C5, rx_q[0]);
      u_spi_host_model.lvl(1'b1);
      u_spi_host_model.sel(1'b1);
      u_spi_host_model.lvl(1'b0);
      u_spi_host_model.xfer(8'h81, 1, 8, 1'b1, got);
      idle(8);
      chk("rx_count", 9'h001, 9'(rx_q.size()));
   endtask
   task automatic t_pause();
      u_spi_host_model.sel(1'b0);
      rx_q.delete();
      u_spi_host_model.xfer(8'h0A, 1, 4, 1'b1, got);
      u_spi_host_model.pin(3, 1'b1, 1'b0);
      idle(8);
      out_phase = 1'b1;
      chk("pause", 9'h001, {8'h00, paused});
      chk("hw_reset", 9'h000, {8'h00, hw_rst});
      u_spi_host_model.xfer(8'hFF, 1, 4, 1'b1, got);
      chk("lane_oe", 9'h000, {5'h00, lane_oe});
      out_phase = 1'b0;
      u_spi_host_model.pin(3, 1'b0, 1'b1);
      idle(8);
      u_spi_host_model.xfer(8'h05, 1, 4, 1'b1, got);
      idle(8);
      chk("rx_word", 9'h1A5, rx_q[0]);
      u_spi_host_model.sel(1'b1);
      fn = 1'b1;
      u_spi_host_model.sel(1'b0);
      u_spi_host_model.pin(3, 1'b1, 1'b0);
      idle(8);
      chk("hw_reset", 9'h001, {8'h00, hw_rst});
      chk("selected", 9'h000, {8'h00, selected});
      u_spi_host_model.pin(3, 1'b0, 1'b1);
      u_spi_host_model.sel(1'b1);
      fn = 1'b0;
   endtask
   task automatic t_protect();
      u_spi_host_model.pin(2, 1'b1, 1'b0);
      idle(8);
      chk("protect", 9'h001, {8'h00, wp});
      qe = 1'b1;
      idle(4);
      chk("protect", 9'h000, {8'h00, wp});
      u_spi_host_model.pin(2, 1'b0, 1'b1);
      qe = 1'b0;
   endtask
   task automatic t_buffer();
      rx_ready = 1'b0;
      u_spi_host_model.sel(1'b0);
      rx_q.delete();
      ovr = 1'b0;
      for (int i = 1; i < 5; i++) u_spi_host_model.xfer(8'(i * 17), 1, 8, 1'b1, got);
      idle(8);
      chk("overrun", 9'h001, {8'h00, ovr});
      rx_ready = 1'b1;
      idle(8);
      chk("rx_count", 9'h003, 9'(rx_q.size()));
      chk("rx_word0", 9'h111, rx_q[0]);
      chk("rx_word1", 9'h022, rx_q[1]);
      chk("rx_word2", 9'h044, rx_q[2]);
      u_spi_host_model.sel(1'b1);
   endtask
   initial begin
      reset = 1'b1;
      lane_mode = flash_pin_pkg::MODE_SINGLE;
      out_phase = 1'b0;
      qe = 1'b0;
      fn = 1'b0;
      tx_valid = 1'b0;
      rx_ready = 1'b1;
      ovr = 1'b0;
      tx_data = 8'h00;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      reset = 1'b0;
      chk("lane_oe", 9'h000, {5'h00, lane_oe});
      chk("standby", 9'h001, {8'h00, standby});
      t_unarmed();
      t_modes();
      t_abandon();
      t_mode3();
      t_pause();
      t_protect();
      t_buffer();
      test_done();
   end
endmodule // tb_flash_pin_front
